// File: design/afrs_pkg.sv
// Constants for the analog frequency-reference selector.
// Assumes digitised samples arrive as signed counts, 16384 counts at 10 V or 20 mA.
package afrs_pkg;
   localparam int CLK_MHZ = 50;
   localparam int NUM_DIN = 6;
   localparam int DIN_CFG_W = 5;
   localparam logic [2:0] SRC_OPERATOR = 3'h0;
   localparam logic [2:0] SRC_TERMINALS = 3'h1;
   localparam logic [2:0] SRC_MAX = 3'h4;
   localparam logic [4:0] CUR_FN_MIN = 5'h01;
   localparam logic [4:0] FN_FREQ_REF = 5'h1F;
   localparam logic [4:0] AUX_FN_AUXREF = 5'h00;
   localparam logic [4:0] AUX_FN_DEF = 5'h1F;
   localparam logic [4:0] DIN_SWITCH = 5'h1F;
   localparam logic [4:0] DIN_STEP1 = 5'h03;
   localparam logic [1:0] LVL_UNI = 2'h0;
   localparam logic [1:0] LVL_BIP = 2'h1;
   localparam logic [1:0] LVL_CUR = 2'h2;
   localparam logic [1:0] CUR_LVL_DEF = 2'h2;
   localparam logic AUX_LVL_DEF = 1'h0;
   // Gains and biases in 0.1 % of maximum frequency
   localparam logic signed [15:0] GAIN_MAX = 16'sh2710;
   localparam logic signed [15:0] GAIN_DEF = 16'sh03E8;
   localparam logic signed [15:0] BIAS_MIN = 16'shFC18;
   localparam logic signed [15:0] BIAS_MAX = 16'sh03E8;
   localparam logic signed [15:0] BIAS_DEF = 16'sh0000;
   // Filter time in 0.01 s
   localparam logic [7:0] FILT_MAX = 8'hC8;
   localparam logic [7:0] FILT_DEF = 8'h00;
   localparam int FILT_SHIFT = 4;
   localparam int FILT_UNIT_US = 625;
   localparam int FILT_UNIT_CYC = FILT_UNIT_US * CLK_MHZ;
   localparam int FS_SHIFT = 14;
   localparam logic signed [16:0] FS_COUNT = 17'sh04000;
   localparam logic signed [16:0] CUR_ZERO = 17'sh00CCD;
   localparam logic [10:0] FREQ_RECIP = 11'h419;
   localparam int FREQ_RSHIFT = 20;
   // Parameter write selectors
   localparam logic [3:0] PSEL_SOURCE = 4'h0;
   localparam logic [3:0] PSEL_CUR_FN = 4'h1;
   localparam logic [3:0] PSEL_CUR_LVL = 4'h2;
   localparam logic [3:0] PSEL_AUX_FN = 4'h3;
   localparam logic [3:0] PSEL_AUX_LVL = 4'h4;
   localparam logic [3:0] PSEL_V_GAIN = 4'h5;
   localparam logic [3:0] PSEL_V_BIAS = 4'h6;
   localparam logic [3:0] PSEL_C_GAIN = 4'h7;
   localparam logic [3:0] PSEL_C_BIAS = 4'h8;
   localparam logic [3:0] PSEL_A_GAIN = 4'h9;
   localparam logic [3:0] PSEL_A_BIAS = 4'hA;
   localparam logic [3:0] PSEL_FILT = 4'hB;
endpackage

// File: design/afrs_scale.sv
// One analog channel: shared-rate lag filter, range decode, gain and bias.
// Assumes filtTick is a one-cycle pulse from the top and samples are synchronous.
`timescale 1ns/100ps
`default_nettype none
module afrs_scale
   import afrs_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic filtTick,
   input wire logic filtBypass,
   input wire logic signed [15:0] sample,
   input wire logic [1:0] level,
   input wire logic signed [15:0] gain,
   input wire logic signed [15:0] bias,
   output logic signed [16:0] pct
);
   logic signed [15:0] yQ;
   logic signed [16:0] diff;
   logic signed [16:0] stepV;
   logic signed [16:0] mag;
   logic signed [16:0] curOff;
   logic signed [19:0] curScaled;
   logic signed [16:0] span;
   logic signed [33:0] prod;
   logic signed [16:0] pctAbs;
   logic neg;

   assign diff = {sample[15], sample} - {yQ[15], yQ};
   assign stepV = diff >>> FILT_SHIFT;

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         yQ <= 16'sh0000;
      end else if (ce) begin
         if (filtBypass) begin
            yQ <= sample;
         end else if (filtTick) begin
            yQ <= yQ + stepV[15:0];
         end
      end
   end

   always_comb begin
      curOff = {yQ[15], yQ} - CUR_ZERO;
      curScaled = 20'sh00000;
      neg = 1'b0;
      mag = 17'sh00000;
      unique case (level)
         LVL_BIP: begin
            neg = yQ[15];
            mag = yQ[15] ? -{yQ[15], yQ} : {yQ[15], yQ};
         end
         LVL_CUR: begin
            // 4 to 20 mA spans 13107 counts; stretch by 5/4, rounded so 20 mA is full scale
            curScaled = (20'(curOff) * 20'sh00005 + 20'sh00002) >>> 2;
            if (curOff[16]) begin
               mag = 17'sh00000;
            end else if (curScaled > 20'(FS_COUNT)) begin
               mag = FS_COUNT;
            end else begin
               mag = curScaled[16:0];
            end
         end
         default: begin
            mag = yQ[15] ? 17'sh00000 : {yQ[15], yQ};
         end
      endcase
      if (mag > FS_COUNT) begin
         mag = FS_COUNT;
      end
      span = {gain[15], gain} - {bias[15], bias};
      prod = 34'(mag) * 34'(span);
      pctAbs = {bias[15], bias} + 17'(prod >>> FS_SHIFT);
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         pct <= 17'sh00000;
      end else if (ce) begin
         pct <= neg ? -pctAbs : pctAbs;
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);

   sequence bypassLoad;
      ce && filtBypass;
   endsequence

   AST_FILT_BYPASS: assert property (
      bypassLoad |=> yQ == $past(sample))
      else $error("Filter bypass did not follow the sample");
   AST_FILT_HOLD: assert property (
      ce && !filtBypass && !filtTick |=> $stable(yQ))
      else $error("Filter moved between steps");
   AST_ZERO_BIAS: assert property (
      ce && level == LVL_UNI && yQ <= 16'sh0000 |=> pct == {$past(bias[15]), $past(bias)})
      else $error("Zero input did not give the bias");
   AST_FULL_GAIN: assert property (
      ce && level == LVL_UNI && yQ >= 16'sh4000 |=> pct == {$past(gain[15]), $past(gain)})
      else $error("Full-scale input did not give the gain");
endmodule
`default_nettype wire

// File: design/afrs_top.sv
// Analog frequency-reference selector: settings, input combination and scaling.
// Assumes all inputs are synchronous to mclk; settings are written one word at a time.
`timescale 1ns/100ps
`default_nettype none
module afrs_top
   import afrs_pkg::*;
#(
   parameter int FILT_UNIT_CYCLES = FILT_UNIT_CYC
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic running,
   input wire logic paramWe,
   input wire logic [3:0] paramSel,
   input wire logic signed [15:0] paramData,
   input wire logic signed [15:0] voltSample,
   input wire logic signed [15:0] curSample,
   input wire logic signed [15:0] auxSample,
   input wire logic [15:0] maximumOutputFrequency,
   input wire logic [15:0] operatorRef,
   input wire logic [NUM_DIN-1:0] dinState,
   input wire logic [NUM_DIN*DIN_CFG_W-1:0] multifunctionDigitalInputCfg,
   output logic [15:0] freqRef,
   output logic reverseDir,
   output logic refValid,
   output logic auxStepActive,
   output logic paramAck,
   output logic paramReject
);
   logic [2:0] referenceSourceSelectQ;
   logic [4:0] currentInputFunctionSelectQ;
   logic [1:0] currentInputLevelSelectQ;
   logic [4:0] auxInputFunctionSelectQ;
   logic auxInputLevelSelectQ;
   logic [7:0] analogFilterTimeQ;
   logic signed [15:0] voltageInputGainQ;
   logic signed [15:0] voltageInputBiasQ;
   logic signed [15:0] currentInputGainQ;
   logic signed [15:0] currentInputBiasQ;
   logic signed [15:0] auxInputGainQ;
   logic signed [15:0] auxInputBiasQ;
   logic locked;
   logic inRange;
   logic writeOk;
   logic [23:0] tickCntQ;
   logic [23:0] tickLimit;
   logic filtTickQ;
   logic filtBypass;
   logic signed [16:0] pctV;
   logic signed [16:0] pctC;
   logic signed [16:0] pctA;
   logic [NUM_DIN-1:0] swCfgV;
   logic [NUM_DIN-1:0] swOnV;
   logic [NUM_DIN-1:0] stepOnV;
   logic curIsRef;
   logic auxIsRef;
   logic switchCfg;
   logic switchOn;
   logic stepUse;
   logic useVolt;
   logic useCur;
   logic terminals;
   logic signed [17:0] refSum;
   logic [17:0] refAbs;
   logic [44:0] freqProd;

   // Write acceptance
   always_comb begin
      locked = paramSel inside {PSEL_SOURCE, PSEL_CUR_FN, PSEL_CUR_LVL, PSEL_AUX_FN,
                                PSEL_AUX_LVL, PSEL_FILT};
      unique case (paramSel)
         PSEL_SOURCE: inRange = paramData >= 16'sh0000 && paramData <= 16'(SRC_MAX);
         PSEL_CUR_FN: inRange = paramData >= 16'(CUR_FN_MIN) && paramData <= 16'(FN_FREQ_REF);
         PSEL_CUR_LVL: inRange = paramData >= 16'sh0000 && paramData <= 16'(LVL_CUR);
         PSEL_AUX_FN: inRange = paramData >= 16'sh0000 && paramData <= 16'(AUX_FN_DEF);
         PSEL_AUX_LVL: inRange = paramData >= 16'sh0000 && paramData <= 16'(LVL_BIP);
         PSEL_V_GAIN, PSEL_C_GAIN, PSEL_A_GAIN: begin
            inRange = paramData >= 16'sh0000 && paramData <= GAIN_MAX;
         end
         PSEL_V_BIAS, PSEL_C_BIAS, PSEL_A_BIAS: begin
            inRange = paramData >= BIAS_MIN && paramData <= BIAS_MAX;
         end
         PSEL_FILT: inRange = paramData >= 16'sh0000 && paramData <= 16'(FILT_MAX);
         default: inRange = 1'b0;
      endcase
      writeOk = paramWe && inRange && !(running && locked);
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         paramAck <= 1'b0;
         paramReject <= 1'b0;
      end else if (ce) begin
         paramAck <= writeOk;
         paramReject <= paramWe && !writeOk;
      end
   end

   // Settings that only change while stopped
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         referenceSourceSelectQ <= SRC_TERMINALS;
         currentInputFunctionSelectQ <= FN_FREQ_REF;
         currentInputLevelSelectQ <= CUR_LVL_DEF;
         auxInputFunctionSelectQ <= AUX_FN_DEF;
         auxInputLevelSelectQ <= AUX_LVL_DEF;
         analogFilterTimeQ <= FILT_DEF;
      end else if (ce && writeOk) begin
         unique case (paramSel)
            PSEL_SOURCE: referenceSourceSelectQ <= paramData[2:0];
            PSEL_CUR_FN: currentInputFunctionSelectQ <= paramData[4:0];
            PSEL_CUR_LVL: currentInputLevelSelectQ <= paramData[1:0];
            PSEL_AUX_FN: auxInputFunctionSelectQ <= paramData[4:0];
            PSEL_AUX_LVL: auxInputLevelSelectQ <= paramData[0];
            PSEL_FILT: analogFilterTimeQ <= paramData[7:0];
            default: ;
         endcase
      end
   end

   // Gains and biases, changeable while running
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         voltageInputGainQ <= GAIN_DEF;
         voltageInputBiasQ <= BIAS_DEF;
         currentInputGainQ <= GAIN_DEF;
         currentInputBiasQ <= BIAS_DEF;
         auxInputGainQ <= GAIN_DEF;
         auxInputBiasQ <= BIAS_DEF;
      end else if (ce && writeOk) begin
         unique case (paramSel)
            PSEL_V_GAIN: voltageInputGainQ <= paramData;
            PSEL_V_BIAS: voltageInputBiasQ <= paramData;
            PSEL_C_GAIN: currentInputGainQ <= paramData;
            PSEL_C_BIAS: currentInputBiasQ <= paramData;
            PSEL_A_GAIN: auxInputGainQ <= paramData;
            PSEL_A_BIAS: auxInputBiasQ <= paramData;
            default: ;
         endcase
      end
   end

   // Shared filter step rate: one step every time/16, so the lag constant is the setting
   assign tickLimit = 24'(int'(analogFilterTimeQ) * FILT_UNIT_CYCLES);
   assign filtBypass = analogFilterTimeQ == FILT_DEF;

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         tickCntQ <= 24'h000000;
         filtTickQ <= 1'b0;
      end else if (ce) begin
         if (filtBypass || tickCntQ + 24'h000001 >= tickLimit) begin
            tickCntQ <= 24'h000000;
            filtTickQ <= !filtBypass;
         end else begin
            tickCntQ <= tickCntQ + 24'h000001;
            filtTickQ <= 1'b0;
         end
      end
   end

   afrs_scale uVolt (
      .mclk(mclk), .nrst(nrst), .ce(ce), .filtTick(filtTickQ), .filtBypass(filtBypass),
      .sample(voltSample), .level(LVL_UNI), .gain(voltageInputGainQ),
      .bias(voltageInputBiasQ), .pct(pctV)
   );
   afrs_scale uCur (
      .mclk(mclk), .nrst(nrst), .ce(ce), .filtTick(filtTickQ), .filtBypass(filtBypass),
      .sample(curSample), .level(currentInputLevelSelectQ), .gain(currentInputGainQ),
      .bias(currentInputBiasQ), .pct(pctC)
   );
   afrs_scale uAux (
      .mclk(mclk), .nrst(nrst), .ce(ce), .filtTick(filtTickQ), .filtBypass(filtBypass),
      .sample(auxSample), .level({1'b0, auxInputLevelSelectQ}), .gain(auxInputGainQ),
      .bias(auxInputBiasQ), .pct(pctA)
   );

   // Multi-function digital input decode
   for (genvar i = 0; i < NUM_DIN; i++) begin : gDin
      logic [4:0] cfg;
      assign cfg = multifunctionDigitalInputCfg[i*DIN_CFG_W +: DIN_CFG_W];
      assign swCfgV[i] = cfg == DIN_SWITCH;
      assign swOnV[i] = swCfgV[i] && dinState[i];
      assign stepOnV[i] = cfg == DIN_STEP1 && dinState[i];
   end

   always_comb begin
      terminals = referenceSourceSelectQ == SRC_TERMINALS;
      curIsRef = currentInputFunctionSelectQ == FN_FREQ_REF;
      auxIsRef = auxInputFunctionSelectQ == AUX_FN_AUXREF;
      switchCfg = |swCfgV;
      switchOn = |swOnV;
      stepUse = auxIsRef && |stepOnV;
      if (switchCfg) begin
         useCur = switchOn && curIsRef;
         useVolt = !useCur;
      end else begin
         useCur = curIsRef;
         useVolt = 1'b1;
      end
      if (stepUse) begin
         refSum = {pctA[16], pctA};
      end else begin
         refSum = (useVolt ? {pctV[16], pctV} : 18'sh00000)
                + (useCur ? {pctC[16], pctC} : 18'sh00000);
      end
      refAbs = refSum[17] ? 18'(-refSum) : 18'(refSum);
      // Percent (0.1 %) times maximum frequency, divided by 1000 via reciprocal
      freqProd = 45'(refAbs) * 45'(maximumOutputFrequency) * 45'(FREQ_RECIP);
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         freqRef <= 16'h0000;
         reverseDir <= 1'b0;
         refValid <= 1'b0;
         auxStepActive <= 1'b0;
      end else if (ce) begin
         auxStepActive <= terminals && stepUse;
         if (terminals) begin
            refValid <= 1'b1;
            reverseDir <= refSum[17];
            freqRef <= (|freqProd[44:36]) ? 16'hFFFF : freqProd[35:FREQ_RSHIFT];
         end else if (referenceSourceSelectQ == SRC_OPERATOR) begin
            refValid <= 1'b1;
            reverseDir <= 1'b0;
            freqRef <= operatorRef;
         end else begin
            refValid <= 1'b0;
            reverseDir <= 1'b0;
            freqRef <= 16'h0000;
         end
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);

   sequence lockedWrite;
      ce && paramWe && running && locked;
   endsequence

   AST_LOCKED_REJECT: assert property (
      lockedWrite |=> paramReject && !paramAck && $stable(currentInputLevelSelectQ))
      else $error("Locked setting accepted while running");
   AST_CUR_LEVEL_RANGE: assert property (
      ce && paramWe && paramSel == PSEL_CUR_LVL && paramData > 16'sh0002 |=> paramReject)
      else $error("Current level above 2 accepted");
   AST_SOURCE_OTHER: assert property (
      ce && !terminals && referenceSourceSelectQ != SRC_OPERATOR |=> !refValid)
      else $error("Reference valid with unused source");
   AST_SWITCH_OFF: assert property (
      switchCfg && !switchOn |-> useVolt && !useCur)
      else $error("Switch off did not select voltage");
   AST_SWITCH_ON: assert property (
      switchCfg && switchOn && curIsRef |-> useCur && !useVolt)
      else $error("Switch on did not select current");
   AST_SUM: assert property (
      ce && terminals && !switchCfg && curIsRef && !stepUse
      |=> reverseDir == ($past(pctV) + $past(pctC) < 0))
      else $error("Direction not from sum of inputs");
   AST_CUR_NOT_REF: assert property (
      !curIsRef && !stepUse |-> refSum == {pctV[16], pctV})
      else $error("Current used without reference code");
   AST_AUX_STEP: assert property (
      ce && terminals && stepUse |=> auxStepActive && reverseDir == $past(pctA[16]))
      else $error("Auxiliary step reference not applied");
endmodule
`default_nettype wire

// File: test/afrs_src_model.sv
// Model of the far side: analog reference sources and digital input contacts.
// Assumes the bench sets target levels; the model presents them one mclk later.
`timescale 1ns/100ps
`default_nettype none
module afrs_src_model (
   input wire logic mclk,
   input wire logic signed [15:0] vSet,
   input wire logic signed [15:0] cSet,
   input wire logic signed [15:0] aSet,
   input wire logic [5:0] dinSet,
   output logic signed [15:0] voltSample,
   output logic signed [15:0] curSample,
   output logic signed [15:0] auxSample,
   output logic [5:0] dinState
);
   // Converter output settles one sample after the source changes
   always_ff @(posedge mclk) begin
      voltSample <= vSet;
      curSample <= cSet;
      auxSample <= aSet;
      dinState <= dinSet;
   end
endmodule
`default_nettype wire

// File: test/analog_freq_reference_select_tb.sv
// Self-checking bench for the analog frequency-reference selector.
// Assumes the source model in afrs_src_model; expectations queued, checked by a monitor.
`timescale 1ns/100ps
`default_nettype none
module analog_freq_reference_select_tb;
   import afrs_pkg::*;
   typedef struct {logic isChk; logic [18:0] val;} afrs_exp_t;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic ce = 1'b1;
   logic running = 1'b0;
   logic paramWe = 1'b0;
   logic [3:0] paramSel = 4'h0;
   logic signed [15:0] paramData = 16'sh0000;
   logic signed [15:0] vSet = 16'sh0000;
   logic signed [15:0] cSet = 16'sh0CCD;
   logic signed [15:0] aSet = 16'sh0000;
   logic [5:0] dinSet = 6'h00;
   logic signed [15:0] voltSample, curSample, auxSample;
   logic [5:0] dinState;
   logic [15:0] maxF = 16'h1770;
   logic [15:0] operatorRef = 16'h0000;
   logic [NUM_DIN*DIN_CFG_W-1:0] dinCfg = '0;
   logic [15:0] freqRef;
   logic reverseDir, refValid, auxStepActive, paramAck, paramReject;
   logic chkReq = 1'b0;
   int err_total = 0;
   int compares = 0;
   int seed = 28;
   afrs_exp_t expQ[$];
   afrs_exp_t e;

   always #10 mclk = ~mclk;

   afrs_src_model u_src (.mclk(mclk), .vSet(vSet), .cSet(cSet), .aSet(aSet),
      .dinSet(dinSet), .voltSample(voltSample), .curSample(curSample),
      .auxSample(auxSample), .dinState(dinState));

   afrs_top #(.FILT_UNIT_CYCLES(4)) u_dut (.mclk(mclk), .nrst(nrst), .ce(ce),
      .running(running), .paramWe(paramWe), .paramSel(paramSel), .paramData(paramData),
      .voltSample(voltSample), .curSample(curSample), .auxSample(auxSample),
      .maximumOutputFrequency(maxF), .operatorRef(operatorRef), .dinState(dinState),
      .multifunctionDigitalInputCfg(dinCfg), .freqRef(freqRef), .reverseDir(reverseDir),
      .refValid(refValid), .auxStepActive(auxStepActive), .paramAck(paramAck),
      .paramReject(paramReject));

   task automatic cmp(string what, logic [18:0] expV, logic [18:0] got);
      compares++;
      if (got !== expV) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, expV, got);
      end
   endtask

   // Frequency in max-frequency units for a percentage in 0.1 % steps
   function automatic logic [15:0] fq(int p);
      longint a;
      a = (p < 0) ? -p : p;
      a = (a * maxF * 1049) >> 20;
      return (a > 65535) ? 16'hFFFF : a[15:0];
   endfunction

   task automatic wr(logic [3:0] sel, int data, logic ack);
      @(posedge mclk);
      paramWe <= 1'b1;
      paramSel <= sel;
      paramData <= 16'(data);
      expQ.push_back('{1'b0, {17'h00000, ack, ~ack}});
      @(posedge mclk);
      paramWe <= 1'b0;
   endtask

   task automatic src(int v, int c, int a);
      @(posedge mclk);
      vSet <= 16'(v);
      cSet <= 16'(c);
      aSet <= 16'(a);
   endtask

   task automatic chkRaw(logic [15:0] f, logic rev, logic valid, logic aux);
      repeat (8) @(posedge mclk);
      expQ.push_back('{1'b1, {f, rev, valid, aux}});
      chkReq <= 1'b1;
      @(posedge mclk);
      chkReq <= 1'b0;
   endtask

   task automatic chk(int p, logic aux);
      chkRaw(fq(p), p < 0, 1'b1, aux);
   endtask

   // Monitor: every answer or check strobe consumes the oldest note
   always @(posedge mclk) begin
      #1;
      if (paramAck === 1'b1 || paramReject === 1'b1 || chkReq) begin
         if (expQ.size() == 0) begin
            cmp("unexpected answer", 19'h00000, 19'h7FFFF);
         end else begin
            e = expQ.pop_front();
            if (e.isChk) begin
               cmp("reference outputs", e.val, {freqRef, reverseDir, refValid, auxStepActive});
            end else begin
               cmp("write answer", e.val, {17'h00000, paramAck, paramReject});
            end
         end
      end
   end

   task automatic results;
      if (expQ.size() != 0) begin
         err_total++;
         $display("wrong value pending notes expected 0 seen %0d", expQ.size());
      end
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge mclk);
      err_total++;
      results();
   end

   initial begin
      repeat (10) @(posedge mclk);
      nrst <= 1'b1;
      src(16384, 3277, 0);
      chk(1000, 1'b0);
      src(8192, 16384, 0);
      chk(1500, 1'b0);
      running <= 1'b1;
      for (int s = 0; s < 5; s++) wr(4'(s), 1, 1'b0);
      wr(PSEL_FILT, 1, 1'b0);
      wr(PSEL_V_GAIN, 2000, 1'b1);
      wr(PSEL_C_BIAS, -1000, 1'b1);
      running <= 1'b0;
      src(8192, 3277, 0);
      chk(0, 1'b0);
      src(8192, 16384, 0);
      chk(2000, 1'b0);
      wr(PSEL_V_GAIN, 1000, 1'b1);
      wr(PSEL_C_BIAS, 0, 1'b1);
      wr(4'hC, 0, 1'b0);
      wr(4'hF, 0, 1'b0);
      wr(PSEL_SOURCE, 5, 1'b0);
      wr(PSEL_CUR_FN, 0, 1'b0);
      wr(PSEL_CUR_FN, 32, 1'b0);
      wr(PSEL_CUR_LVL, 3, 1'b0);
      wr(PSEL_AUX_LVL, 2, 1'b0);
      wr(PSEL_AUX_FN, 32, 1'b0);
      wr(PSEL_V_GAIN, 10001, 1'b0);
      wr(PSEL_C_GAIN, -1, 1'b0);
      wr(PSEL_V_BIAS, -1001, 1'b0);
      wr(PSEL_C_BIAS, 1001, 1'b0);
      wr(PSEL_FILT, 201, 1'b0);
      wr(PSEL_FILT, 200, 1'b1);
      wr(PSEL_FILT, 0, 1'b1);
      wr(PSEL_V_BIAS, -1000, 1'b1);
      src(0, 3277, 0);
      chk(-1000, 1'b0);
      wr(PSEL_V_BIAS, 0, 1'b1);
      wr(PSEL_CUR_LVL, 1, 1'b1);
      src(0, -16384, 0);
      chk(-1000, 1'b0);
      src(0, 8192, 0);
      chk(500, 1'b0);
      wr(PSEL_CUR_LVL, 0, 1'b1);
      src(0, -8192, 0);
      chk(0, 1'b0);
      wr(PSEL_CUR_LVL, 2, 1'b1);
      wr(PSEL_CUR_FN, 2, 1'b1);
      src(0, 16384, 0);
      chk(0, 1'b0);
      wr(PSEL_CUR_FN, 31, 1'b1);
      dinCfg[4:0] <= DIN_SWITCH;
      src(8192, 16384, 0);
      chk(500, 1'b0);
      dinSet <= 6'h01;
      chk(1000, 1'b0);
      dinSet <= 6'h00;
      dinCfg[4:0] <= 5'h00;
      operatorRef <= 16'($random(seed));
      wr(PSEL_SOURCE, 0, 1'b1);
      chkRaw(operatorRef, 1'b0, 1'b1, 1'b0);
      for (int s = 2; s < 5; s++) begin
         wr(PSEL_SOURCE, s, 1'b1);
         chkRaw(16'h0000, 1'b0, 1'b0, 1'b0);
      end
      wr(PSEL_SOURCE, 1, 1'b1);
      wr(PSEL_AUX_FN, 0, 1'b1);
      dinCfg[9:5] <= DIN_STEP1;
      src(8192, 3277, 16384);
      chk(500, 1'b0);
      dinSet <= 6'h02;
      chk(1000, 1'b1);
      wr(PSEL_AUX_LVL, 1, 1'b1);
      src(8192, 3277, -8192);
      chk(-500, 1'b1);
      wr(PSEL_A_GAIN, 2000, 1'b1);
      chk(-1000, 1'b1);
      dinSet <= 6'h00;
      chk(500, 1'b0);
      ce <= 1'b0;
      src(16384, 3277, 0);
      chk(500, 1'b0);
      ce <= 1'b1;
      chk(1000, 1'b0);
      results();
   end
endmodule
`default_nettype wire
